/* cfb_consts.svh */
// Constants of the cyclic fieldbus data image: offsets, bit positions, timing.
// Assumes inclusion by bare name from any file of the block.
`ifndef CFB_CONSTS_SVH
`define CFB_CONSTS_SVH

// Image geometry
`define CFB_IMG_LAST      6'h3b
`define CFB_IDX_DONE      6'h3c

// Input image byte offsets
`define CFB_IB_STATUS     6'h00
`define CFB_IB_FAULT      6'h03
`define CFB_IB_BOTTLE     6'h07
`define CFB_IB_UNIT       6'h08
`define CFB_IB_PROG       6'h09
`define CFB_IB_TSAMPLE    6'h0a
`define CFB_IB_TUPPER     6'h0c
`define CFB_IB_DIN        6'h10
`define CFB_IB_RELAY      6'h12
`define CFB_IB_ANA        6'h14
`define CFB_IB_NAME       6'h20
`define CFB_IB_NAME_LAST  6'h29

// Output image byte offsets
`define CFB_OB_CMD        6'h00
`define CFB_OB_BOTTLE     6'h03
`define CFB_OB_RELAY      6'h10
`define CFB_OB_ANA        6'h12

// Command bits of output byte 0
`define CFB_CMD_PSTART    0
`define CFB_CMD_PSTOP     1
`define CFB_CMD_SAMPLE    2
`define CFB_CMD_BOTTLE    3
`define CFB_CMD_CHANGE    4
`define CFB_CMD_EVENT     5
`define CFB_CMD_EXTSTOP   6

// Status byte bits
`define CFB_ST_FAULT      1
`define CFB_ST_OVERFLOW   6
`define CFB_ANA_OK_BIT    0
`define CFB_ANA_OC_BIT    1

// Fault mask: weight 2048 unused
`define CFB_FAULT_USED    17'h1f7ff
// Analogue scale ceiling
`define CFB_ANA_MAX       16'h07d0

// Timing
`define CFB_CYCLE_MS      1000
`define CFB_CLK_NS        40
`define CFB_CYCLE_CYCLES  (`CFB_CYCLE_MS * 1000000 / `CFB_CLK_NS)

`endif

/* cfb_pkg.sv */
// Types of the cyclic fieldbus data image block.
// Assumes nothing beyond a SystemVerilog compiler.
package cfb_pkg;

	// Sampling mode source setting
	typedef enum logic [1:0] {SMODE_LOCAL, SMODE_BUS, SMODE_FLOW_BUS} cfb_smode_e;

	// Transmit sequencer states
	typedef enum logic {TX_IDLE, TX_SEND} cfb_txst_e;

endpackage

/* cfb_cycle_timer.sv */
// One-pulse-per-exchange-cycle timer.
// Assumes a free-running core clock; CYCLES may be shortened in simulation.
`timescale 1ns/1ps
`default_nettype none
module cfb_cycle_timer #(
	parameter int unsigned CYCLES = 25000000
)(
	input  wire logic core_clk,
	input  wire logic rst_n,
	output logic      tick_q
);

	logic [31:0] count_q;   // Cycles since last tick

	// Count up one exchange period, pulse at wrap
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_q <= 32'h0;
			tick_q  <= 1'b0;
		end
		else if (count_q == 32'(CYCLES - 1))
		begin
			count_q <= 32'h0;
			tick_q  <= 1'b1;
		end
		else
		begin
			count_q <= count_q + 32'h1;
			tick_q  <= 1'b0;
		end
	end

endmodule
`default_nettype wire

/* cfb_bus_mux.sv */
// Registered source select: bus value or local value.
// Assumes sel and both values synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module cfb_bus_mux #(
	parameter int W = 1
)(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         sel,
	input  wire logic [W-1:0] busVal,
	input  wire logic [W-1:0] localVal,
	output logic      [W-1:0] out_q
);

	// Follow bus only when configured for bus control
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			out_q <= '0;
		else
			out_q <= sel ? busVal : localVal;
	end

endmodule
`default_nettype wire

/* cfb_image.sv */
// Cyclic fieldbus data image: builds the 60-byte input image, takes the
// 60-byte output image and gates master commands by the source settings.
// Assumes a byte stream link to the coupler with valid/ready on transmit
// and valid plus first-byte marker on receive, all on core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "cfb_consts.svh"

// Behaviour
// - Both images are fixed sixty bytes, 0-59.
// - Full images exchanged once each one-second cycle.
// - Byte 0 carries the activity flags.
// - Byte 0 bit 6 flags bottle full.
// - Byte 0 bit 1 fault; bytes 3-6 fault mask.
// - Fault mask one weight per fault; 2048 unused.
// - Bottle position byte 7; temperatures bytes 10-13.
// - Byte 8 holds unit status flags.
// - Byte 9 holds programme status flags.
// - Bytes 16 and 18 mirror inputs, relays.
// - Bytes 20-22 analogue value plus status byte.
// - Analogue values scaled zero to 2000.
// - Bytes 32-41 hold the programme name.
// - Byte 59 is XOR of bytes 0-58.
// - Report own analogue; use bus only if selected.
// - Bus sampling only in bus sampling mode.
// - Flow option plus flow bus mode starts cycle.
// - Bottle commands only in bus distribution mode.
// - Relay follows bus only if configured so.
// - Changeover request needs bus switch setting.
// - Event request needs bus event setting.
// - Stop, start, stop honoured without settings.
module cfb_image #(
	parameter int unsigned CYCLE_CYCLES = `CFB_CYCLE_CYCLES
)(
	input  wire logic               core_clk,
	input  wire logic               rst_n,
	// Transmit stream toward the coupler
	output logic                    txValid_q,
	output logic                    txFirst_q,
	output logic [7:0]              txData_q,
	input  wire logic               txReady,
	// Receive stream from the coupler
	input  wire logic               rxValid,
	input  wire logic               rxFirst,
	input  wire logic [7:0]         rxData,
	output logic                    rxFrameOk_q,
	output logic                    rxCheckErr_q,
	// Device state reported to the master
	input  wire logic               samplingActive,
	input  wire logic               tapMoving,
	input  wire logic               mainProgActive,
	input  wire logic               changeProgActive,
	input  wire logic               eventProgActive,
	input  wire logic               overflowFull,
	input  wire logic [16:0]        faultMask,
	input  wire logic [7:0]         bottleActual,
	input  wire logic [2:0]         unitStatus,
	input  wire logic [6:0]         progStatus,
	input  wire logic [15:0]        tempSample,
	input  wire logic [15:0]        tempUpper,
	input  wire logic [2:0]         digIn,
	input  wire logic [15:0]        anaLocal,
	input  wire logic               anaValid,
	input  wire logic               anaOpen,
	input  wire logic [79:0]        progName,
	input  wire logic [2:0]         relayLocal,
	// Source settings
	input  wire cfb_pkg::cfb_smode_e sampleMode,
	input  wire logic               flowOptionFitted,
	input  wire logic               distBusMode,
	input  wire logic [2:0]         relayBusMode,
	input  wire logic               anaSrcBus,
	input  wire logic               progSwitchBus,
	input  wire logic               eventBus,
	// Gated commands toward the device
	output logic                    sampleStart_q,
	output logic                    flowSampleStart_q,
	output logic                    bottleChange_q,
	output logic [7:0]              bottleTarget_q,
	output logic [2:0]              relayOut_q,
	output logic [15:0]             anaUsed_q,
	output logic                    changeoverReq_q,
	output logic                    eventReq_q,
	output logic                    extStop_q,
	output logic                    progStart_q,
	output logic                    progStop_q
);

	logic                 cycleTick;     // Start of an exchange cycle
	cfb_pkg::cfb_txst_e   txState_q;     // Transmit sequencer
	logic [5:0]           txIdx_q;       // Byte being offered
	logic [7:0]           txXor_q;       // XOR of bytes already accepted
	logic [5:0]           nextIdx;       // Index of the byte to load
	logic [7:0]           nextByte;      // Image byte at nextIdx
	logic [31:0]          faultWord;     // Fault mask with unused weight cleared
	logic [15:0]          anaClamped;    // Local analogue limited to scale
	logic [5:0]           rxIdx;         // Index of the byte now arriving
	logic [5:0]           rxIdx_q;       // Next expected receive index
	logic [7:0]           rxXor_q;       // Running XOR of received bytes
	logic [7:0]           rxCmd_q;       // Frame command byte
	logic [7:0]           rxBottle_q;    // Frame bottle position
	logic [2:0]           rxRelay_q;     // Frame relay bits
	logic [15:0]          rxAna_q;       // Frame analogue value
	logic                 commit;        // Good check byte arriving
	logic [7:0]           cmd_q;         // Last accepted command byte
	logic [7:0]           prevCmd_q;     // Command byte before that
	logic [7:0]           cmdRise;       // Commands newly raised at commit
	logic [2:0]           relayBus_q;    // Accepted relay bits
	logic [15:0]          anaBus_q;      // Accepted analogue, clamped

	// Exchange cycle pacing
	cfb_cycle_timer #(.CYCLES(CYCLE_CYCLES)) u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tick_q   (cycleTick)
	);

	// Fault weights, 2048 forced clear
	assign faultWord  = {15'h0, faultMask & `CFB_FAULT_USED};
	// Analogue scaled 0..2000
	assign anaClamped = (anaLocal > `CFB_ANA_MAX) ? `CFB_ANA_MAX : anaLocal;

	// Index of the byte loaded next
	always_comb
	begin
		nextIdx = (txState_q == cfb_pkg::TX_IDLE) ? 6'h0 : txIdx_q + 6'h1;
	end

	// Input image byte map, multi-byte fields most significant first
	always_comb
	begin
		nextByte = 8'h0;                                    // Unassigned bytes zero
		unique case (nextIdx)
			`CFB_IB_STATUS:                                 // Activity and fault flags
				nextByte = {1'b0, overflowFull, eventProgActive, changeProgActive,
					mainProgActive, tapMoving, |faultWord, samplingActive};
			`CFB_IB_FAULT:        nextByte = faultWord[31:24];
			`CFB_IB_FAULT + 6'h1: nextByte = faultWord[23:16];
			`CFB_IB_FAULT + 6'h2: nextByte = faultWord[15:8];
			`CFB_IB_FAULT + 6'h3: nextByte = faultWord[7:0];
			`CFB_IB_BOTTLE:       nextByte = bottleActual;
			`CFB_IB_UNIT:         nextByte = {5'h0, unitStatus};
			`CFB_IB_PROG:         nextByte = {1'b0, progStatus};
			`CFB_IB_TSAMPLE:      nextByte = tempSample[15:8];
			`CFB_IB_TSAMPLE + 6'h1: nextByte = tempSample[7:0];
			`CFB_IB_TUPPER:       nextByte = tempUpper[15:8];
			`CFB_IB_TUPPER + 6'h1: nextByte = tempUpper[7:0];
			`CFB_IB_DIN:          nextByte = {5'h0, digIn};
			`CFB_IB_RELAY:        nextByte = {5'h0, relayOut_q};
			`CFB_IB_ANA:          nextByte = anaClamped[15:8];   // Own signal always
			`CFB_IB_ANA + 6'h1:   nextByte = anaClamped[7:0];
			`CFB_IB_ANA + 6'h2:   nextByte = {6'h0, anaOpen, anaValid};
			`CFB_IMG_LAST:        nextByte = txXor_q ^ txData_q; // Check byte
			default:
			begin
				// Programme name field
				if (nextIdx >= `CFB_IB_NAME && nextIdx <= `CFB_IB_NAME_LAST)
					nextByte = progName[8 * int'(`CFB_IB_NAME_LAST - nextIdx) +: 8];
			end
		endcase
	end

	// Transmit sequencer: one 60-byte image per tick
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			txState_q <= cfb_pkg::TX_IDLE;
			txIdx_q   <= 6'h0;
			txXor_q   <= 8'h0;
			txValid_q <= 1'b0;
			txFirst_q <= 1'b0;
			txData_q  <= 8'h0;
		end
		else
		begin
			unique case (txState_q)
				cfb_pkg::TX_IDLE:
				begin
					// Tick while still sending is skipped
					if (cycleTick)
					begin
						txState_q <= cfb_pkg::TX_SEND;
						txIdx_q   <= 6'h0;
						txXor_q   <= 8'h0;
						txValid_q <= 1'b1;
						txFirst_q <= 1'b1;
						txData_q  <= nextByte;
					end
				end
				cfb_pkg::TX_SEND:
				begin
					if (txReady)
					begin
						txFirst_q <= 1'b0;
						if (txIdx_q == `CFB_IMG_LAST)
						begin
							// Image complete
							txState_q <= cfb_pkg::TX_IDLE;
							txValid_q <= 1'b0;
						end
						else
						begin
							txIdx_q  <= nextIdx;
							txXor_q  <= txXor_q ^ txData_q;
							txData_q <= nextByte;
						end
					end
				end
			endcase
		end
	end

	// Receive position; first-byte marker resynchronises
	assign rxIdx  = rxFirst ? 6'h0 : rxIdx_q;
	// Check byte matches XOR of bytes 0..58
	assign commit = rxValid && rxIdx == `CFB_IMG_LAST && rxXor_q == rxData;

	// Receive capture of the fields this block acts on
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rxIdx_q      <= `CFB_IDX_DONE;
			rxXor_q      <= 8'h0;
			rxCmd_q      <= 8'h0;
			rxBottle_q   <= 8'h0;
			rxRelay_q    <= 3'h0;
			rxAna_q      <= 16'h0;
			rxFrameOk_q  <= 1'b0;
			rxCheckErr_q <= 1'b0;
		end
		else
		begin
			rxFrameOk_q  <= commit;
			rxCheckErr_q <= rxValid && rxIdx == `CFB_IMG_LAST && !commit;
			// Bytes beyond 59 ignored until next first byte
			if (rxValid && rxIdx != `CFB_IDX_DONE)
			begin
				rxIdx_q <= rxIdx + 6'h1;
				rxXor_q <= (rxIdx == 6'h0) ? rxData : rxXor_q ^ rxData;
				unique case (rxIdx)
					`CFB_OB_CMD:          rxCmd_q         <= rxData;
					`CFB_OB_BOTTLE:       rxBottle_q      <= rxData;
					`CFB_OB_RELAY:        rxRelay_q       <= rxData[2:0];
					`CFB_OB_ANA:          rxAna_q[15:8]   <= rxData;
					`CFB_OB_ANA + 6'h1:   rxAna_q[7:0]    <= rxData;
					default:              rxXor_q         <= (rxIdx == 6'h0) ? rxData : rxXor_q ^ rxData;
				endcase
			end
		end
	end

	// Accepted image; a bad check byte leaves the previous one standing
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmd_q      <= 8'h0;
			prevCmd_q  <= 8'h0;
			relayBus_q <= 3'h0;
			anaBus_q   <= 16'h0;
		end
		else if (commit)
		begin
			cmd_q      <= rxCmd_q;
			prevCmd_q  <= cmd_q;
			relayBus_q <= rxRelay_q;
			anaBus_q   <= (rxAna_q > `CFB_ANA_MAX) ? `CFB_ANA_MAX : rxAna_q;
		end
	end

	// Triggered commands act once on the rising bit
	assign cmdRise = rxCmd_q & ~cmd_q;

	// Gated trigger pulses, one cycle after commit
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sampleStart_q     <= 1'b0;
			flowSampleStart_q <= 1'b0;
			bottleChange_q    <= 1'b0;
			bottleTarget_q    <= 8'h0;
			progStart_q       <= 1'b0;
			progStop_q        <= 1'b0;
		end
		else
		begin
			// Sampling only in bus mode
			sampleStart_q     <= commit && cmdRise[`CFB_CMD_SAMPLE] && sampleMode == cfb_pkg::SMODE_BUS;
			// Flow cycle needs option and flow bus mode
			flowSampleStart_q <= commit && cmdRise[`CFB_CMD_SAMPLE] && flowOptionFitted
				&& sampleMode == cfb_pkg::SMODE_FLOW_BUS;
			// Bottle change only in bus distribution mode
			bottleChange_q    <= commit && cmdRise[`CFB_CMD_BOTTLE] && distBusMode;
			if (commit && cmdRise[`CFB_CMD_BOTTLE] && distBusMode)
				bottleTarget_q <= rxBottle_q;
			// No setting needed
			progStart_q       <= commit && cmdRise[`CFB_CMD_PSTART];
			progStop_q        <= commit && cmdRise[`CFB_CMD_PSTOP];
		end
	end

	// Held requests, live while the master holds the bit
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			changeoverReq_q <= 1'b0;
			eventReq_q      <= 1'b0;
			extStop_q       <= 1'b0;
		end
		else
		begin
			changeoverReq_q <= cmd_q[`CFB_CMD_CHANGE] && progSwitchBus;
			eventReq_q      <= cmd_q[`CFB_CMD_EVENT] && eventBus;
			extStop_q       <= cmd_q[`CFB_CMD_EXTSTOP];
		end
	end

	// Relay drive per output source setting
	for (genvar i = 0; i < 3; i++)
	begin : g_relay
		cfb_bus_mux #(.W(1)) u_relay (
			.core_clk (core_clk),
			.rst_n    (rst_n),
			.sel      (relayBusMode[i]),
			.busVal   (relayBus_q[i]),
			.localVal (relayLocal[i]),
			.out_q    (relayOut_q[i])
		);
	end

	// Analogue used by the device
	cfb_bus_mux #(.W(16)) u_ana (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.sel      (anaSrcBus),
		.busVal   (anaBus_q),
		.localVal (anaClamped),
		.out_q    (anaUsed_q)
	);

	// Checks
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	int unsigned tickGap_q;   // Cycles since last tick
	logic        tickSeen_q;  // A tick has occurred

	// Tick spacing helper
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tickGap_q  <= 0;
			tickSeen_q <= 1'b0;
		end
		else
		begin
			tickGap_q  <= cycleTick ? 0 : tickGap_q + 1;
			tickSeen_q <= tickSeen_q | cycleTick;
		end
	end

	cycle_period_a: assert property (cycleTick && tickSeen_q |-> tickGap_q == CYCLE_CYCLES - 1)
		else $error("exchange tick spacing wrong");
	image_len_a: assert property (txValid_q && txReady && txIdx_q == `CFB_IMG_LAST |=> !txValid_q)
		else $error("image longer than sixty bytes");
	status_flags_a: assert property ($rose(txValid_q) |-> txData_q[0] == $past(samplingActive)
		&& txData_q[3] == $past(mainProgActive))
		else $error("status byte flags wrong");
	overflow_bit_a: assert property ($rose(txValid_q) |-> txData_q[`CFB_ST_OVERFLOW] == $past(overflowFull))
		else $error("overflow flag wrong");
	check_byte_a: assert property (txValid_q && txIdx_q == `CFB_IMG_LAST |-> txData_q == txXor_q)
		else $error("check byte not XOR of image");
	unused_zero_a: assert property (txValid_q && txIdx_q == 6'h1 |-> txData_q == 8'h0)
		else $error("unassigned byte not zero");
	sample_gate_a: assert property (sampleStart_q |-> $past(sampleMode) == cfb_pkg::SMODE_BUS)
		else $error("sampling started outside bus mode");
	bottle_gate_a: assert property (bottleChange_q |-> $past(distBusMode))
		else $error("bottle change outside bus mode");
	change_gate_a: assert property (changeoverReq_q |-> $past(progSwitchBus))
		else $error("changeover without bus switch");
	event_gate_a: assert property (eventReq_q |-> $past(eventBus))
		else $error("event without bus setting");
	ext_stop_a: assert property (commit ##1 1'b1 |=> extStop_q == $past(cmd_q[`CFB_CMD_EXTSTOP]))
		else $error("external stop not followed");

endmodule
`default_nettype wire

/* cfb_coupler_model.sv */
// Coupler model: collects input images from the block and sends output images to it.
// Assumes the block's byte stream ports, all on core_clk.
`timescale 1ns/1ps
`default_nettype none
module cfb_coupler_model (
	input  wire logic       core_clk,
	input  wire logic       slow,
	input  wire logic       txValid,
	input  wire logic       txFirst,
	input  wire logic [7:0] txData,
	output logic            txReady,
	output logic            rxValid,
	output logic            rxFirst,
	output logic [7:0]      rxData
);
	logic [7:0] inImg [60];    // Last complete input image
	logic [7:0] part [60];     // Image being collected
	int         idx = 0;       // Next byte index
	int         frames = 0;    // Complete images taken
	int         cyc = 0;       // Free-running cycle count
	int         startCyc [2];  // Start cycles of the last two images

	// Idle levels at time zero
	initial
	begin
		txReady = 1'b0;
		rxValid = 1'b0;
		rxFirst = 1'b0;
		rxData = 8'h5a;
	end

	// Ready toggles every cycle when stalling, else stays high
	always @(negedge core_clk)
		txReady <= slow ? ~txReady : 1'b1;

	// Collect input image bytes on each accepted transfer
	always @(posedge core_clk)
	begin
		cyc = cyc + 1;
		if (txValid && txReady)
		begin
			if (txFirst)
			begin
				startCyc[0] = startCyc[1];
				startCyc[1] = cyc;
			end
			part[txFirst ? 0 : idx] = txData;
			idx = txFirst ? 1 : idx + 1;
			if (idx == 60)
			begin
				inImg = part;
				frames = frames + 1;
			end
		end
	end

	// Send one output image, with a gap mid-way and a good or spoiled check byte
	task automatic send_img(input logic [7:0] cmd, input logic [7:0] bottle, input logic [2:0] relay,
		input logic [15:0] ana, input logic bad);
		logic [7:0] img [60];
		logic [7:0] bcc;
		bcc = 8'h00;
		for (int i = 0; i < 60; i++)
			img[i] = 8'h00;
		img[0] = cmd;
		img[3] = bottle;
		img[16] = {5'h00, relay};
		img[18] = ana[15:8];
		img[19] = ana[7:0];
		for (int i = 0; i < 59; i++)
			bcc ^= img[i];
		img[59] = bad ? ~bcc : bcc;
		for (int i = 0; i < 60; i++)
		begin
			@(negedge core_clk);
			if (i == 30)
			begin
				rxValid <= 1'b0;
				rxData <= ~rxData;
				@(negedge core_clk);
			end
			rxValid <= 1'b1;
			rxFirst <= (i == 0);
			rxData <= img[i];
		end
		@(negedge core_clk);
		rxValid <= 1'b0;
		rxFirst <= 1'b0;
		rxData <= ~rxData;
	endtask
endmodule
`default_nettype wire

/* testbench.sv */
// Testbench of the cyclic data image block with a coupler model.
// Assumes cfb_image, cfb_pkg and cfb_coupler_model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int unsigned CYC = 200; // Shortened exchange period
	logic               core_clk = 1'b0;
	logic               rst_n, slow, txValid_q, txFirst_q, txReady, rxValid, rxFirst;
	logic [7:0]         txData_q, rxData, bottleActual, bottleTarget_q;
	logic               rxFrameOk_q, rxCheckErr_q, samplingActive, tapMoving, mainProgActive;
	logic               changeProgActive, eventProgActive, overflowFull, anaValid, anaOpen;
	logic [16:0]        faultMask;
	logic [2:0]         unitStatus, digIn, relayLocal, relayBusMode, relayOut_q;
	logic [6:0]         progStatus;
	logic [15:0]        tempSample, tempUpper, anaLocal, anaUsed_q;
	logic [79:0]        progName;
	cfb_pkg::cfb_smode_e sampleMode;
	logic               flowOptionFitted, distBusMode, anaSrcBus, progSwitchBus, eventBus;
	logic               sampleStart_q, flowSampleStart_q, bottleChange_q, changeoverReq_q, eventReq_q;
	logic               extStop_q, progStart_q, progStop_q;
	logic [6:0]         pulses;    // Pulse outputs side by side
	int                 cnt [7];   // Pulse counts since last clear
	int                 err_total = 0;
	int                 checked = 0;
	int                 cycles = 0;

	// Clock of 40 ns
	always #20 core_clk = ~core_clk;

	cfb_image #(.CYCLE_CYCLES(CYC)) u_cfb_image (
		.core_clk(core_clk), .rst_n(rst_n), .txValid_q(txValid_q), .txFirst_q(txFirst_q),
		.txData_q(txData_q), .txReady(txReady), .rxValid(rxValid), .rxFirst(rxFirst), .rxData(rxData),
		.rxFrameOk_q(rxFrameOk_q), .rxCheckErr_q(rxCheckErr_q), .samplingActive(samplingActive),
		.tapMoving(tapMoving), .mainProgActive(mainProgActive), .changeProgActive(changeProgActive),
		.eventProgActive(eventProgActive), .overflowFull(overflowFull), .faultMask(faultMask),
		.bottleActual(bottleActual), .unitStatus(unitStatus), .progStatus(progStatus),
		.tempSample(tempSample), .tempUpper(tempUpper), .digIn(digIn), .anaLocal(anaLocal),
		.anaValid(anaValid), .anaOpen(anaOpen), .progName(progName), .relayLocal(relayLocal),
		.sampleMode(sampleMode), .flowOptionFitted(flowOptionFitted), .distBusMode(distBusMode),
		.relayBusMode(relayBusMode), .anaSrcBus(anaSrcBus), .progSwitchBus(progSwitchBus),
		.eventBus(eventBus), .sampleStart_q(sampleStart_q), .flowSampleStart_q(flowSampleStart_q),
		.bottleChange_q(bottleChange_q), .bottleTarget_q(bottleTarget_q), .relayOut_q(relayOut_q),
		.anaUsed_q(anaUsed_q), .changeoverReq_q(changeoverReq_q), .eventReq_q(eventReq_q),
		.extStop_q(extStop_q), .progStart_q(progStart_q), .progStop_q(progStop_q));

	cfb_coupler_model u_cfb_coupler_model (
		.core_clk(core_clk), .slow(slow), .txValid(txValid_q), .txFirst(txFirst_q), .txData(txData_q),
		.txReady(txReady), .rxValid(rxValid), .rxFirst(rxFirst), .rxData(rxData));

	assign pulses = {rxCheckErr_q, rxFrameOk_q, progStop_q, progStart_q, bottleChange_q,
		flowSampleStart_q, sampleStart_q};

	// Count pulses; watchdog ends a hung run
	always @(posedge core_clk)
	begin
		for (int i = 0; i < 7; i++)
			cnt[i] += (pulses[i] === 1'b1);
		cycles++;
		if (cycles == 4000)
		begin
			err_total++;
			end_sim();
		end
	end

	// Compare and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Wait until the coupler holds n complete images
	task automatic wait_frames(input int n);
		while (u_cfb_coupler_model.frames < n)
			@(negedge core_clk);
	endtask

	// Compare the last input image against one built from the inputs
	task automatic chk_img();
		logic [7:0]  e [60];
		logic [7:0]  bcc;
		logic [16:0] mask;
		bcc = 8'h00;
		mask = faultMask & 17'h1f7ff;
		for (int i = 0; i < 60; i++)
			e[i] = 8'h00;
		e[0] = {1'b0, overflowFull, eventProgActive, changeProgActive, mainProgActive, tapMoving, |mask,
			samplingActive};
		{e[3], e[4], e[5], e[6]} = {15'h0000, mask};
		e[7] = bottleActual;
		e[8] = {5'h00, unitStatus};
		e[9] = {1'b0, progStatus};
		{e[10], e[11], e[12], e[13]} = {tempSample, tempUpper};
		e[16] = {5'h00, digIn};
		e[18] = {5'h00, relayLocal};
		{e[20], e[21]} = (anaLocal > 16'h07d0) ? 16'h07d0 : anaLocal;
		e[22] = {6'h00, anaOpen, anaValid};
		for (int i = 0; i < 10; i++)
			e[32 + i] = progName[79 - 8 * i -: 8];
		for (int i = 0; i < 59; i++)
			bcc ^= e[i];
		e[59] = bcc;
		for (int i = 0; i < 60; i++)
			chk(u_cfb_coupler_model.inImg[i], e[i]);
	endtask

	// Send one output image and wait for its levels to settle
	task automatic rx(input logic [7:0] cmd, input logic [7:0] bot, input logic [2:0] rel,
		input logic [15:0] ana, input logic bad);
		for (int i = 0; i < 7; i++)
			cnt[i] = 0;
		u_cfb_coupler_model.send_img(cmd, bot, rel, ana, bad);
		repeat (4) @(negedge core_clk);
	endtask

	// Compare pulse counts against one bit each
	task automatic chk_cnt(input logic [6:0] exp);
		for (int i = 0; i < 7; i++)
			chk(cnt[i], {31'h0, exp[i]});
	endtask

	// Main sequence
	initial
	begin
		rst_n = 1'b0;
		slow = 1'b0;
		{samplingActive, tapMoving, mainProgActive, changeProgActive} = 4'h9;
		{eventProgActive, overflowFull, anaValid, anaOpen} = 4'he;
		faultMask = 17'h10801;
		bottleActual = 8'h0c;
		unitStatus = 3'h5;
		progStatus = 7'h55;
		tempSample = 16'h1234;
		tempUpper = 16'habcd;
		digIn = 3'h6;
		anaLocal = 16'h0900;
		progName = "PROGNAME01";
		relayLocal = 3'h2;
		sampleMode = cfb_pkg::SMODE_LOCAL;
		{flowOptionFitted, distBusMode, anaSrcBus, progSwitchBus, eventBus} = 5'h00;
		relayBusMode = 3'h0;
		repeat (4) @(negedge core_clk);
		rst_n = 1'b1;
		// Input image with faults, coupler always ready
		wait_frames(2);
		chk_img();
		chk(u_cfb_coupler_model.startCyc[1] - u_cfb_coupler_model.startCyc[0], CYC);
		chk(anaUsed_q, 16'h07d0);
		// Fault-free image, coupler stalling
		faultMask = 17'h00000;
		slow = 1'b1;
		wait_frames(3);
		chk_img();
		slow = 1'b0;
		// All commands, no bus settings: only start, stop and external stop act
		rx(8'h7f, 8'h05, 3'h7, 16'h0100, 1'b0);
		chk_cnt(7'b0111000);
		chk({extStop_q, changeoverReq_q, eventReq_q}, 3'b100);
		chk(relayOut_q, 3'h2);
		chk(anaUsed_q, 16'h07d0);
		rx(8'h00, 8'h00, 3'h0, 16'h0000, 1'b0);
		chk({extStop_q, changeoverReq_q, eventReq_q}, 3'b000);
		// All commands with bus settings
		sampleMode = cfb_pkg::SMODE_BUS;
		{distBusMode, anaSrcBus, progSwitchBus, eventBus} = 4'hf;
		relayBusMode = 3'h5;
		rx(8'h7f, 8'h09, 3'h3, 16'h0123, 1'b0);
		chk_cnt(7'b0111101);
		chk(bottleTarget_q, 8'h09);
		chk(relayOut_q, 3'h3);
		chk(anaUsed_q, 16'h0123);
		chk({extStop_q, changeoverReq_q, eventReq_q}, 3'b111);
		rx(8'h00, 8'h00, 3'h0, 16'h0000, 1'b0);
		// Flow sampling by the bus, bus analogue above scale
		sampleMode = cfb_pkg::SMODE_FLOW_BUS;
		flowOptionFitted = 1'b1;
		rx(8'h04, 8'h00, 3'h0, 16'h0fff, 1'b0);
		chk_cnt(7'b0100010);
		chk(anaUsed_q, 16'h07d0);
		chk(relayOut_q, 3'h2);
		// Spoiled check byte: image dropped, previous values stand
		rx(8'h7f, 8'h0b, 3'h7, 16'h0001, 1'b1);
		chk_cnt(7'b1000000);
		chk({extStop_q, changeoverReq_q, eventReq_q}, 3'b000);
		chk(bottleTarget_q, 8'h09);
		chk(anaUsed_q, 16'h07d0);
		end_sim();
	end
endmodule
`default_nettype wire
